// >>> verilog/bsx_exec.sv
// AXI4-Lite front end and executor for bit, shift and stack operations.
//
// Overview of operation
// - Push stores a register on the stack in two cycles, flags kept.
// - Pop loads a register from the stack in two cycles, flags kept.
// - I/O bit set forces one I/O bit to one in two cycles, flags kept.
// - I/O bit clear forces one I/O bit to zero in two cycles, flags kept.
// - Rotate left takes C into bit 0, bit 7 into C and sets Z C N V.
// - Rotate right takes C into bit 7, bit 0 into C and sets Z C N V.
// - Bit store copies a register bit to T in one cycle, only T changes.
// - Bit load copies T into a register bit in one cycle, no flag changes.
// - The overflow set and clear operations change only V, in one cycle.
// - Half-carry set and clear operations change only H, in one cycle.
// - The sign set and clear operations change only S, in one cycle.
// - Sleep and watchdog restart pulse their unit in one cycle, no flags.
module bsx_exec (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [bsx_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bsx_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic sleep_req,
	output logic watchdog_restart
);
	import bsx_pkg::*;

	// ==========================================================
	// Storage
	logic [7:0] gpr_q [GPR_N];
	logic [7:0] io_q [IO_N];
	logic [7:0] stk_q [STK_N];
	bsx_flags_t status_flag_register_q;
	logic [7:0] sp_q;
	logic [7:0] slp_cnt_q;
	logic [7:0] wdr_cnt_q;
	logic [7:0] io_tmp_q;
	bsx_cmd_t cmd_q;
	bsx_state_t state_q;

	// ==========================================================
	// Write channel capture
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_have_q;
	logic w_have_q;
	logic wr_go;
	logic [1:0] wseg;
	logic [5:0] widx;
	logic wr_lo;

	assign wseg = waddr_q[9:8];
	assign widx = waddr_q[7:2];
	assign wr_lo = wstrb_q[0];
	// Bus writes wait for an idle executor, so no storage sees two writers.
	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid &&
		(state_q == ST_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_have_q <= 1'b0;
			waddr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_have_q <= 1'b1;
			waddr_q <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_have_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_have_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
			w_have_q <= 1'b0;
		end
	end

	logic wmapped;
	always_comb begin
		wmapped = 1'b1;
		if (wseg == SEG_CTL && widx > CTL_SP) begin
			wmapped = 1'b0;
		end else if (wseg == SEG_GPR && widx >= 6'(GPR_N)) begin
			wmapped = 1'b0;
		end else if (wseg == SEG_IO && widx >= 6'(IO_N)) begin
			wmapped = 1'b0;
		end else if (wseg == SEG_STK && widx >= 6'(STK_N)) begin
			wmapped = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wmapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Executor sequencing
	logic launch;
	logic two_cycle;
	bsx_op_t cur_op;
	bsx_alu_out_t alu_out;

	assign launch = wr_go && wseg == SEG_CTL && widx == CTL_CMD && wr_lo;
	assign cur_op = bsx_op_t'(cmd_q.op);
	assign two_cycle = cur_op == OP_PUSH || cur_op == OP_POP ||
		cur_op == SET_IO_BIT_OP || cur_op == CLEAR_IO_BIT_OP;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q <= '0;
		end else if (launch) begin
			cmd_q <= bsx_cmd_t'(wdata_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: state_q <= launch ? ST_FIRST : ST_IDLE;
				ST_FIRST: state_q <= two_cycle ? ST_SECOND : ST_IDLE;
				ST_SECOND: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	bsx_alu bsx_alu_inst (
		.op(cur_op),
		.operand(gpr_q[cmd_q.rd]),
		.bitsel(cmd_q.bitsel),
		.flags_in(status_flag_register_q),
		.alu_out(alu_out)
	);

	// ==========================================================
	// Working registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < GPR_N; i++) begin
				gpr_q[i] <= BYTE_RST;
			end
		end else if (wr_go && wseg == SEG_GPR && wr_lo &&
				widx < 6'(GPR_N)) begin
			gpr_q[widx[4:0]] <= wdata_q[7:0];
		end else if (state_q == ST_FIRST && alu_out.wr_reg) begin
			gpr_q[cmd_q.rd] <= alu_out.result;
		end else if (state_q == ST_SECOND && cur_op == OP_POP) begin
			gpr_q[cmd_q.rd] <= stk_q[sp_q[3:0]];
		end
	end

	// Flags load from the ALU in every first cycle; push, pop and I/O bit ops pass them through unchanged.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_flag_register_q <= bsx_flags_t'(FLAGS_RST);
		end else if (wr_go && wseg == SEG_CTL && widx == CTL_FLAGS &&
				wr_lo) begin
			status_flag_register_q <= bsx_flags_t'(wdata_q[7:0]);
		end else if (state_q == ST_FIRST) begin
			status_flag_register_q <= alu_out.flags;
		end
	end

	// ==========================================================
	// Stack: push stores then decrements, pop increments then loads.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_q <= SP_RST;
		end else if (wr_go && wseg == SEG_CTL && widx == CTL_SP && wr_lo) begin
			sp_q <= wdata_q[7:0];
		end else if (state_q == ST_SECOND && cur_op == OP_PUSH) begin
			sp_q <= sp_q - 8'h01;
		end else if (state_q == ST_FIRST && cur_op == OP_POP) begin
			sp_q <= sp_q + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < STK_N; i++) begin
				stk_q[i] <= BYTE_RST;
			end
		end else if (wr_go && wseg == SEG_STK && wr_lo &&
				widx < 6'(STK_N)) begin
			stk_q[widx[3:0]] <= wdata_q[7:0];
		end else if (state_q == ST_FIRST && cur_op == OP_PUSH) begin
			stk_q[sp_q[3:0]] <= gpr_q[cmd_q.rd];
		end
	end

	// ==========================================================
	// I/O space: first cycle reads, second cycle writes the changed bit.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_tmp_q <= BYTE_RST;
		end else if (state_q == ST_FIRST) begin
			io_tmp_q <= io_q[cmd_q.io_addr];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < IO_N; i++) begin
				io_q[i] <= BYTE_RST;
			end
		end else if (wr_go && wseg == SEG_IO && wr_lo &&
				widx < 6'(IO_N)) begin
			io_q[widx[4:0]] <= wdata_q[7:0];
		end else if (state_q == ST_SECOND && cur_op == SET_IO_BIT_OP) begin
			io_q[cmd_q.io_addr] <= io_tmp_q | (8'h01 << cmd_q.bitsel);
		end else if (state_q == ST_SECOND && cur_op == CLEAR_IO_BIT_OP) begin
			io_q[cmd_q.io_addr] <= io_tmp_q & ~(8'h01 << cmd_q.bitsel);
		end
	end

	// ==========================================================
	// Sleep and watchdog hand-off pulses with issue counters.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_req <= 1'b0;
			watchdog_restart <= 1'b0;
		end else begin
			sleep_req <= state_q == ST_FIRST && cur_op == OP_SLEEP;
			watchdog_restart <= state_q == ST_FIRST &&
				cur_op == WATCHDOG_RESTART_OP;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slp_cnt_q <= BYTE_RST;
			wdr_cnt_q <= BYTE_RST;
		end else if (state_q == ST_FIRST && cur_op == OP_SLEEP) begin
			slp_cnt_q <= slp_cnt_q + 8'h01;
		end else if (state_q == ST_FIRST && cur_op == WATCHDOG_RESTART_OP) begin
			wdr_cnt_q <= wdr_cnt_q + 8'h01;
		end
	end

	// ==========================================================
	// Read channel
	logic [1:0] rseg;
	logic [5:0] ridx;
	logic [31:0] rd_d;
	logic [1:0] rresp_d;

	assign rseg = s_axi_araddr[9:8];
	assign ridx = s_axi_araddr[7:2];

	always_comb begin
		rd_d = '0;
		rresp_d = RESP_OKAY;
		unique case (rseg)
			SEG_CTL: begin
				if (ridx == CTL_CMD) begin
					rd_d = cmd_q;
				end else if (ridx == CTL_FLAGS) begin
					rd_d[7:0] = status_flag_register_q;
				end else if (ridx == CTL_SP) begin
					rd_d[7:0] = sp_q;
				end else if (ridx == CTL_STAT) begin
					rd_d[STAT_BUSY] = state_q != ST_IDLE;
					rd_d[STAT_SLP_LSB +: 8] = slp_cnt_q;
					rd_d[STAT_WDR_LSB +: 8] = wdr_cnt_q;
				end else begin
					rresp_d = RESP_SLVERR;
				end
			end
			SEG_GPR: begin
				if (ridx < 6'(GPR_N)) begin
					rd_d[7:0] = gpr_q[ridx[4:0]];
				end else begin
					rresp_d = RESP_SLVERR;
				end
			end
			SEG_IO: begin
				if (ridx < 6'(IO_N)) begin
					rd_d[7:0] = io_q[ridx[4:0]];
				end else begin
					rresp_d = RESP_SLVERR;
				end
			end
			SEG_STK: begin
				if (ridx < 6'(STK_N)) begin
					rd_d[7:0] = stk_q[ridx[3:0]];
				end else begin
					rresp_d = RESP_SLVERR;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_d;
			s_axi_rresp <= rresp_d;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// >>> verilog/bsx_pkg.sv
// Constants, opcodes and carrier types for the bit, shift and stack executor.
package bsx_pkg;

	// ==========================================================
	// Bus and memory map
	localparam int unsigned ADDR_W = 12;
	localparam logic [1:0] SEG_CTL = 2'h0;
	localparam logic [1:0] SEG_GPR = 2'h1;
	localparam logic [1:0] SEG_IO = 2'h2;
	localparam logic [1:0] SEG_STK = 2'h3;
	localparam logic [5:0] CTL_CMD = 6'h00;
	localparam logic [5:0] CTL_FLAGS = 6'h01;
	localparam logic [5:0] CTL_SP = 6'h02;
	localparam logic [5:0] CTL_STAT = 6'h03;
	localparam int unsigned GPR_N = 32;
	localparam int unsigned IO_N = 32;
	localparam int unsigned STK_N = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] SP_RST = 8'h0f;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ==========================================================
	// Command and status word field positions
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_RD_LSB = 8;
	localparam int unsigned CMD_BIT_LSB = 16;
	localparam int unsigned CMD_IO_LSB = 24;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_SLP_LSB = 8;
	localparam int unsigned STAT_WDR_LSB = 16;

	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_PUSH = 5'h01,
		OP_POP = 5'h02,
		SET_IO_BIT_OP = 5'h03,
		CLEAR_IO_BIT_OP = 5'h04,
		LOGICAL_LEFT_SHIFT_OP = 5'h05,
		LOGICAL_RIGHT_SHIFT_OP = 5'h06,
		ROTATE_LEFT_CARRY_OP = 5'h07,
		ROTATE_RIGHT_CARRY_OP = 5'h08,
		ARITH_RIGHT_SHIFT_OP = 5'h09,
		OP_NIBBLE_SWAP = 5'h0a,
		BIT_TO_TFLAG_OP = 5'h0b,
		TFLAG_TO_BIT_OP = 5'h0c,
		OVERFLOW_FLAG_SET_OP = 5'h0d,
		OVERFLOW_FLAG_CLEAR_OP = 5'h0e,
		HALFCARRY_SET_OP = 5'h0f,
		HALFCARRY_CLEAR_OP = 5'h10,
		SIGN_FLAG_SET_OP = 5'h11,
		SIGN_FLAG_CLEAR_OP = 5'h12,
		OP_SLEEP = 5'h13,
		WATCHDOG_RESTART_OP = 5'h14
	} bsx_op_t;

	// Executor states, Gray coded along idle, first, second.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FIRST = 2'b01,
		ST_SECOND = 2'b11
	} bsx_state_t;

	// Status flag register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic i;
		logic t;
		logic h;
		logic s;
		logic v;
		logic n;
		logic z;
		logic c;
	} bsx_flags_t;

	typedef struct packed {
		logic [2:0] io_hi;
		logic [4:0] io_addr;
		logic [4:0] bit_hi;
		logic [2:0] bitsel;
		logic [2:0] rd_hi;
		logic [4:0] rd;
		logic [2:0] op_hi;
		logic [4:0] op;
	} bsx_cmd_t;

	typedef struct packed {
		logic [7:0] result;
		logic wr_reg;
		bsx_flags_t flags;
	} bsx_alu_out_t;

endpackage

// >>> verilog/bsx_alu.sv
// Single-cycle shift, bit transfer and flag operations on one working byte.
module bsx_alu (
	input wire bsx_pkg::bsx_op_t op,
	input wire logic [7:0] operand,
	input wire logic [2:0] bitsel,
	input wire bsx_pkg::bsx_flags_t flags_in,
	output bsx_pkg::bsx_alu_out_t alu_out
);
	import bsx_pkg::*;

	logic [7:0] res;
	logic cout;
	logic shifted;

	always_comb begin
		alu_out = '0;
		alu_out.flags = flags_in;
		res = operand;
		cout = flags_in.c;
		shifted = 1'b0;
		unique case (op)
			LOGICAL_LEFT_SHIFT_OP: begin
				res = {operand[6:0], 1'b0};
				cout = operand[7];
				shifted = 1'b1;
			end
			LOGICAL_RIGHT_SHIFT_OP: begin
				res = {1'b0, operand[7:1]};
				cout = operand[0];
				shifted = 1'b1;
			end
			ROTATE_LEFT_CARRY_OP: begin
				res = {operand[6:0], flags_in.c};
				cout = operand[7];
				shifted = 1'b1;
			end
			ROTATE_RIGHT_CARRY_OP: begin
				res = {flags_in.c, operand[7:1]};
				cout = operand[0];
				shifted = 1'b1;
			end
			ARITH_RIGHT_SHIFT_OP: begin
				res = {operand[7], operand[7:1]};
				cout = operand[0];
				shifted = 1'b1;
			end
			OP_NIBBLE_SWAP: begin
				res = {operand[3:0], operand[7:4]};
				alu_out.wr_reg = 1'b1;
			end
			BIT_TO_TFLAG_OP: begin
				alu_out.flags.t = operand[bitsel];
			end
			TFLAG_TO_BIT_OP: begin
				res[bitsel] = flags_in.t;
				alu_out.wr_reg = 1'b1;
			end
			OVERFLOW_FLAG_SET_OP: alu_out.flags.v = 1'b1;
			OVERFLOW_FLAG_CLEAR_OP: alu_out.flags.v = 1'b0;
			HALFCARRY_SET_OP: alu_out.flags.h = 1'b1;
			HALFCARRY_CLEAR_OP: alu_out.flags.h = 1'b0;
			SIGN_FLAG_SET_OP: alu_out.flags.s = 1'b1;
			SIGN_FLAG_CLEAR_OP: alu_out.flags.s = 1'b0;
			default: begin
			end
		endcase
		if (shifted) begin
			// Shifts touch Z, C, N and V; V is N exclusive-or C.
			alu_out.wr_reg = 1'b1;
			alu_out.flags.z = (res == 8'h00);
			alu_out.flags.c = cout;
			alu_out.flags.n = res[7];
			alu_out.flags.v = res[7] ^ cout;
		end
		alu_out.result = res;
	end

endmodule

// >>> sim/bsx_exec_monitor.sv
// Concurrent checks on the executor's bus handshakes and unit pulses.
module bsx_exec_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_req,
	input wire logic watchdog_restart
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========
	// Bus channel rules
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before acceptance");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before acceptance");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not given one cycle after address");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready ##[0:3] s_axi_bvalid)
		else $error("write response late or address taken twice");

	// ==========
	// Unit pulses
	a_sleep_pulse: assert property (sleep_req |=> !sleep_req)
		else $error("sleep request longer than one cycle");
	a_wdr_pulse: assert property (watchdog_restart
		|=> !watchdog_restart)
		else $error("watchdog restart longer than one cycle");
	a_pulse_cause: assert property ($rose(sleep_req)
		|| $rose(watchdog_restart) |-> $past(s_axi_bvalid))
		else $error("unit pulse without a preceding command write");
	a_pulse_single: assert property (!(sleep_req && watchdog_restart))
		else $error("sleep and watchdog pulses together");
endmodule

bind bsx_exec bsx_exec_monitor bsx_exec_monitor_inst (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.sleep_req(sleep_req),
	.watchdog_restart(watchdog_restart)
);

// >>> sim/bsx_exec_bench.sv
// Self-checking bench for the bit, shift and stack executor.
module bsx_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import bsx_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, sleep_req, wd_pulse;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int failures = 0;
	int cmp_count = 0;
	int sleep_seen = 0;
	int wd_seen = 0;
	bsx_op_t sop[6] = '{LOGICAL_LEFT_SHIFT_OP, LOGICAL_RIGHT_SHIFT_OP,
		ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP, ARITH_RIGHT_SHIFT_OP,
		OP_NIBBLE_SWAP};
	logic [7:0] ops[2] = '{8'h81, 8'h01};
	logic [7:0] fls[2] = '{8'h01, 8'hf4};
	bsx_op_t fop[8] = '{OVERFLOW_FLAG_SET_OP, OVERFLOW_FLAG_CLEAR_OP,
		HALFCARRY_SET_OP, HALFCARRY_CLEAR_OP, SIGN_FLAG_SET_OP,
		SIGN_FLAG_CLEAR_OP, OP_SLEEP, WATCHDOG_RESTART_OP};
	logic [7:0] fin[8] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h5a,
		8'ha5};
	logic [7:0] fex[8] = '{8'h08, 8'hf7, 8'h20, 8'hdf, 8'h10, 8'hef, 8'h5a,
		8'ha5};

	initial begin
		forever #12.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		sleep_seen += int'(sleep_req === 1'b1);
		wd_seen += int'(wd_pulse === 1'b1);
	end

	bsx_exec bsx_exec_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.sleep_req(sleep_req),
		.watchdog_restart(wd_pulse)
	);

	// ==========
	// Checking and bus tasks
	task automatic tally_and_finish();
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic hang();
		failures++;
		tally_and_finish();
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er = 2'h0);
		int n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 40);
		bready <= 1'b0;
		if (bvalid !== 1'b1) hang();
		check("bresp", 32'(bresp), 32'(er));
	endtask

	task automatic rd(logic [11:0] a, logic [31:0] e, string nm,
		logic [1:0] er = 2'h0);
		int n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 40);
		rready <= 1'b0;
		if (rvalid !== 1'b1) hang();
		check(nm, rdata, e);
		check("rresp", 32'(rresp), 32'(er));
	endtask

	task automatic run(bsx_op_t o, logic [4:0] r, logic [2:0] b,
		logic [4:0] p);
		wr(12'h000, {3'h0, p, 5'h0, b, 3'h0, r, 3'h0, o});
	endtask

	// Result in the upper byte, flags in the lower byte.
	function automatic logic [15:0] shf(bsx_op_t o, logic [7:0] a,
		logic [7:0] f);
		logic [7:0] r;
		logic c;
		c = (o == LOGICAL_LEFT_SHIFT_OP || o == ROTATE_LEFT_CARRY_OP) ?
			a[7] : a[0];
		case (o)
			LOGICAL_LEFT_SHIFT_OP: r = {a[6:0], 1'b0};
			ROTATE_LEFT_CARRY_OP: r = {a[6:0], f[0]};
			LOGICAL_RIGHT_SHIFT_OP: r = {1'b0, a[7:1]};
			ROTATE_RIGHT_CARRY_OP: r = {f[0], a[7:1]};
			ARITH_RIGHT_SHIFT_OP: r = {a[7], a[7:1]};
			default: return {a[3:0], a[7:4], f};
		endcase
		return {r, f[7:4], r[7] ^ c, r[7], r == 8'h00, c};
	endfunction

	// ==========
	// Main sequence
	initial begin
		logic [15:0] e;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h004, {24'h0, FLAGS_RST}, "flags after reset");
		rd(12'h008, {24'h0, SP_RST}, "sp after reset");
		rd(12'h00c, 32'h0, "status after reset");
		rd(12'h010, 32'h0, "unmapped read", RESP_SLVERR);
		wr(12'h00c, 32'h1, RESP_SLVERR);
		wr(12'h010, 32'h1, RESP_SLVERR);
		foreach (sop[i]) begin
			for (int k = 0; k < 2; k++) begin
				e = shf(sop[i], ops[k], fls[k]);
				wr(12'h114, {24'h0, ops[k]});
				wr(12'h004, {24'h0, fls[k]});
				run(sop[i], 5'd5, 3'd0, 5'd0);
				rd(12'h114, 32'(e[15:8]), "result");
				rd(12'h004, 32'(e[7:0]), "flags");
			end
		end
		wr(12'h11c, 32'h20);
		wr(12'h004, 32'hbf);
		run(BIT_TO_TFLAG_OP, 5'd7, 3'd5, 5'd0);
		rd(12'h004, 32'hff, "t from bit 5");
		run(TFLAG_TO_BIT_OP, 5'd7, 3'd3, 5'd0);
		rd(12'h11c, 32'h28, "bit 3 from t");
		rd(12'h004, 32'hff, "flags after load");
		run(BIT_TO_TFLAG_OP, 5'd7, 3'd0, 5'd0);
		rd(12'h004, 32'hbf, "t from bit 0");
		run(TFLAG_TO_BIT_OP, 5'd7, 3'd5, 5'd0);
		rd(12'h11c, 32'h08, "bit 5 from t");
		foreach (fop[i]) begin
			wr(12'h004, {24'h0, fin[i]});
			run(fop[i], 5'd0, 3'd0, 5'd0);
			rd(12'h004, {24'h0, fex[i]}, "flag op");
		end
		check("sleep pulses", 32'(sleep_seen), 32'h1);
		check("watchdog pulses", 32'(wd_seen), 32'h1);
		rd(12'h00c, 32'h0001_0100, "unit counts");
		wr(12'h10c, 32'ha5);
		wr(12'h300, 32'h3e);
		wr(12'h004, 32'h3c);
		run(OP_PUSH, 5'd3, 3'd0, 5'd0);
		run(OP_POP, 5'd9, 3'd0, 5'd0);
		rd(12'h33c, 32'ha5, "pushed byte");
		rd(12'h124, 32'ha5, "popped byte");
		rd(12'h008, 32'h0f, "sp after pair");
		run(OP_POP, 5'd10, 3'd0, 5'd0);
		rd(12'h128, 32'h3e, "pop past top");
		rd(12'h008, 32'h10, "sp after pop");
		rd(12'h004, 32'h3c, "flags after stack");
		wr(12'h27c, 32'h00);
		run(SET_IO_BIT_OP, 5'd0, 3'd7, 5'd31);
		run(SET_IO_BIT_OP, 5'd0, 3'd0, 5'd31);
		run(CLEAR_IO_BIT_OP, 5'd0, 3'd7, 5'd31);
		rd(12'h27c, 32'h01, "io set and clear");
		wstrb <= 4'he;
		wr(12'h27c, 32'hff);
		wstrb <= 4'hf;
		rd(12'h27c, 32'h01, "masked write");
		wr(12'h200, 32'hff);
		run(CLEAR_IO_BIT_OP, 5'd0, 3'd0, 5'd0);
		rd(12'h200, 32'hfe, "io clear");
		rd(12'h004, 32'h3c, "flags after io");
		run(OP_NOP, 5'd0, 3'd0, 5'd0);
		rd(12'h004, 32'h3c, "flags after nop");
		rd(12'h200, 32'hfe, "io after nop");
		tally_and_finish();
	end
endmodule
